// >>> hdl/slss_consts.svh
`ifndef SLSS_CONSTS_SVH
`define SLSS_CONSTS_SVH
// command-error threshold past the detection point, in position counts
`define SLSS_OVERRUN_LIMIT    32'sh0000001E
// input function codes for the pin assignment settings
`define SLSS_FN_FWD_END       8'h0A
`define SLSS_FN_REV_END       8'h0B
`define SLSS_FN_PROX_DOG      8'h22
// status word bit that reports an active travel end
`define SLSS_STATUS_LIMIT_BIT 12
`define SLSS_POS_ZERO         32'sh00000000
`define SLSS_STATUS_ZERO      16'h0000
`endif

// >>> hdl/slss_pkg.sv
package slss_pkg;
    typedef logic signed [31:0] slss_pos_t;
    typedef logic [15:0] slss_status_t;
    // control modes of the controller
    typedef enum logic [2:0] {
        SLSS_MODE_CSP = 3'h0,
        SLSS_MODE_CSV = 3'h1,
        SLSS_MODE_PP  = 3'h2,
        SLSS_MODE_PV  = 3'h3,
        SLSS_MODE_PT  = 3'h4,
        SLSS_MODE_JOG = 3'h5,
        SLSS_MODE_HM  = 3'h6
    } slss_mode_t;
    // controller recovery states, gray along the usual path
    typedef enum logic [1:0] {
        SLSS_RUN    = 2'b00,
        SLSS_FOLLOW = 2'b01,
        SLSS_CHECK  = 2'b11,
        SLSS_BACK   = 2'b10
    } slss_rec_t;
endpackage

// >>> hdl/slss_if.sv
`timescale 1ns/1ns
interface slss_if;
    import slss_pkg::*;
    slss_mode_t   mode;               // control mode in force
    slss_pos_t    target_pos;         // cyclic position command
    slss_pos_t    target_vel;         // cyclic velocity command
    logic         ctrl_upper_limit_in; // controller limit, high = clear
    logic         ctrl_lower_limit_in; // controller limit, high = clear
    slss_status_t status_word;        // device status word
    slss_pos_t    actual_pos;         // device actual position
    logic         homing_done;        // controller finished homing
    logic         home_valid;         // device holds a home position
    modport dev  (input mode, target_pos, target_vel, ctrl_upper_limit_in,
                  ctrl_lower_limit_in, homing_done,
                  output status_word, actual_pos, home_valid);
    modport ctrl (output mode, target_pos, target_vel, ctrl_upper_limit_in,
                  ctrl_lower_limit_in, homing_done,
                  input status_word, actual_pos, home_valid);
endinterface

// >>> hdl/slss_device.sv
`timescale 1ns/1ns
`include "slss_consts.svh"
// Summary of operation
// - stop motor when any limit input goes off
// - controller freezes position command at travel end
// - command error when csp overrun exceeds thirty counts
// - command error erases the home position
// - erased output follows alarm when selected
// - controller flags need_homing after erased home
// - csp: follow actual, check bit, then reverse
// - csv: check bit, then reverse velocity
// - profile position: target opposite the limit
// - table and jog: move opposite the limit
// - warning select enables or hides limit warning
// - auto-on forces travel-end inputs on
// - three pins map to selectable input functions
// - scope setting limits switches to homing
// - source setting picks pins or controller
// - pole setting suppresses limits during detection
// - direction setting swaps upper and lower pin reports

// the limit inputs and the reported limits are high while clear, so a
// broken wire reads as a reached end and stops the motor
// all settings are static levels; nothing here is reached over a bus
module slss_device #(
    parameter int PINS = 3 // number of assignable input pins
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    slss_if.dev                    link,
    input  wire logic [PINS-1:0]   input_pin,            // raw pins, high = on
    input  wire logic [7:0]        input_map_a,          // function on pin 0
    input  wire logic [7:0]        input_map_b,          // function on pin 1
    input  wire logic [7:0]        input_map_c,          // function on pin 2
    input  wire logic              limit_warning_select, // 1 hides warning
    input  wire logic              travel_end_auto_on,   // 1 forces ends on
    input  wire logic              limit_enable_scope,   // 1 homing only
    input  wire logic              sensor_source_select, // 1 controller signals
    input  wire logic              erased_output_select, // 1 drives erased out
    input  wire logic              pole_detect_limit_select, // 1 off in pole detect
    input  wire logic              pole_detect_active,   // pole detection running
    input  wire logic              travel_direction_select,
    input  wire slss_pkg::slss_pos_t motor_pos,          // measured position
    output logic                   motor_stop,           // stop request
    output logic                   upper_travel_limit,   // reported, high = clear
    output logic                   lower_travel_limit,   // reported, high = clear
    output logic                   travel_limit_warning,
    output logic                   command_error_alarm,
    output logic                   position_erased_out,
    output logic                   home_proximity        // dog input, high = on
);
    import slss_pkg::*;

    // synchroniser stages, one bit per pin
    logic [PINS-1:0] sync_a;        // first stage, read only by sync_b
    logic [PINS-1:0] sync_b;        // stable pin samples
    logic [PINS-1:0] next_sync_a;
    logic [PINS-1:0] next_sync_b;
    // pin functions and their decoded, synchronised levels
    logic [7:0]      pin_fn [PINS]; // function assigned to each pin
    logic [PINS-1:0] is_fwd, is_rev, is_dog;
    logic            fwd_travel_end, rev_travel_end; // high = clear
    // limit view after source, direction and scope are applied
    logic            upper_ok, lower_ok, limits_live, hit;
    // held state: alarm, home, detection point and erased flag
    logic            alarm, next_alarm;
    logic            home, next_home;
    logic            latched, next_latched;          // detection point held
    slss_pos_t       det_pos, next_det_pos;
    logic            erased, next_erased;

    // pin assignment: each pin carries whatever function its map names;
    // a code that matches no limit or dog function leaves the pin unused,
    // and two pins given the same function are simply or-ed together
    assign pin_fn[0] = input_map_a;
    assign pin_fn[1] = input_map_b;
    assign pin_fn[2] = input_map_c;

    // two-flop synchroniser per pin
    // the pins come straight from field switches, so a sample taken mid-change
    // could resolve differently in two places; only the second stage is read
    // reset clears both stages, so the ends read off and the motor is held
    // stopped for the two edges it takes the real pin levels to arrive
    always_comb begin
        next_sync_a = input_pin;
        next_sync_b = sync_a;
    end
    // register the synchroniser stages
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    // function decode per pin
    // one compare per pin and function; the decode sits after the
    // synchroniser so a change of map never meets a raw, unsettled pin
    // a set bit means the function is asserted on that pin
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            assign is_fwd[g] = (pin_fn[g] == `SLSS_FN_FWD_END) && sync_b[g];
            assign is_rev[g] = (pin_fn[g] == `SLSS_FN_REV_END) && sync_b[g];
            assign is_dog[g] = (pin_fn[g] == `SLSS_FN_PROX_DOG) && sync_b[g];
        end
    endgenerate

    // limit evaluation; an unassigned end reads as off, which fails safe
    // auto-on overrides the pins for machines with no travel limit at all
    // the controller source bypasses both the pins and the direction swap,
    // since the controller already names its limits by address direction
    // limits_live gates hit, and with it the stop, warning and status bit, but not
    // the reported levels, so those still show an open switch while it is ignored
    // the pole setting only matters while a pole detection run is active
    always_comb begin
        fwd_travel_end = travel_end_auto_on | (|is_fwd);
        rev_travel_end = travel_end_auto_on | (|is_rev);
        if (sensor_source_select) begin
            upper_ok = link.ctrl_upper_limit_in;
            lower_ok = link.ctrl_lower_limit_in;
        end else if (travel_direction_select) begin
            upper_ok = rev_travel_end;
            lower_ok = fwd_travel_end;
        end else begin
            upper_ok = fwd_travel_end;
            lower_ok = rev_travel_end;
        end
        // scope and pole detection can each take the limits out of play
        limits_live = (!limit_enable_scope || link.mode == SLSS_MODE_HM)
                   && !(pole_detect_active && pole_detect_limit_select);
        // either reported level low is a reached end
        hit = limits_live && !(upper_ok && lower_ok);
    end

    // alarm, home and detection point
    // latched trails hit by one edge and drives the status bit the
    // controller watches; the detection point is captured on the first
    // cycle of a hit and kept while the hit lasts
    // the overrun test is two-sided, since either end can be the one hit;
    // an overrun outranks a homing pulse in the same cycle, so the alarm
    // and the loss of home are never dropped by a late homing report
    always_comb begin
        next_latched = hit;
        next_det_pos = det_pos;
        next_alarm   = alarm;
        next_home    = home;
        next_erased  = erased;
        if (hit && !latched) begin
            next_det_pos = motor_pos; // point where the end was seen
        end
        // overrun beyond the detection point in csp only
        // other modes move by profile, so no frozen command is owed there
        if (latched && link.mode == SLSS_MODE_CSP &&
            ((link.target_pos - det_pos > `SLSS_OVERRUN_LIMIT) ||
             (det_pos - link.target_pos > `SLSS_OVERRUN_LIMIT))) begin
            next_alarm  = 1'b1;
            next_home   = 1'b0;
            next_erased = erased_output_select;
        end else if (link.homing_done) begin
            next_alarm  = 1'b0;
            next_home   = 1'b1;
            next_erased = 1'b0;
        end
    end
    // state registers; reset leaves no home, so homing is needed after
    // every reset before absolute positioning can be trusted
    // the detection point resets to zero but is only read while latched
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            latched <= 1'b0;
            det_pos <= `SLSS_POS_ZERO;
            alarm   <= 1'b0;
            home    <= 1'b0;
            erased  <= 1'b0;
        end else begin
            latched <= next_latched;
            det_pos <= next_det_pos;
            alarm   <= next_alarm;
            home    <= next_home;
            erased  <= next_erased;
        end
    end

    // outputs; stop stays even with the warning hidden
    // the stop request also holds through a command error, so a motor
    // whose home was erased does not move again until homing has run
    // the reported limits are the mapped levels, or the controller levels under the controller source, high while clear
    // the dog is forced low under the controller source, as no
    // controller-side dog signal is carried on the link
    // the status word carries only the travel-end bit; others read zero
    // actual position is passed through unchanged for the follow step
    always_comb begin
        motor_stop           = hit || alarm;
        travel_limit_warning = hit && !limit_warning_select;
        command_error_alarm  = alarm;
        position_erased_out  = erased;
        upper_travel_limit   = upper_ok;
        lower_travel_limit   = lower_ok;
        home_proximity       = sensor_source_select ? 1'b0 : (|is_dog);
        link.status_word     = `SLSS_STATUS_ZERO;
        link.status_word[`SLSS_STATUS_LIMIT_BIT] = latched;
        link.actual_pos      = motor_pos;
        link.home_valid      = home;
    end
endmodule // slss_device

// >>> hdl/slss_controller.sv
`timescale 1ns/1ns
`include "slss_consts.svh"
module slss_controller (
    input  wire logic                clk,
    input  wire logic                reset_n,
    slss_if.ctrl                     link,
    input  wire slss_pkg::slss_mode_t  user_mode,
    input  wire slss_pkg::slss_pos_t   user_pos,       // wanted position
    input  wire slss_pkg::slss_pos_t   user_vel,       // wanted velocity
    input  wire slss_pkg::slss_pos_t   back_step,      // recovery step, positive
    input  wire logic                user_upper_in,  // limit wired here
    input  wire logic                user_lower_in,
    input  wire logic                at_upper,       // which limit is active
    input  wire logic                homing_finish,  // homing run complete
    output logic                     need_homing,    // home lost, home first
    output slss_pkg::slss_rec_t      rec_state
);
    import slss_pkg::*;

    slss_rec_t state, next_state;
    slss_pos_t pos, next_pos;
    slss_pos_t vel, next_vel;
    logic      limit_bit;

    // recovery sequence per mode
    always_comb begin
        limit_bit  = link.status_word[`SLSS_STATUS_LIMIT_BIT];
        next_state = state;
        next_pos   = pos;
        next_vel   = vel;
        case (state)
            SLSS_RUN: begin
                next_pos = user_pos;
                next_vel = user_vel;
                if (limit_bit) begin
                    next_pos   = pos;
                    next_state = SLSS_FOLLOW;
                end
            end
            SLSS_FOLLOW: begin
                next_pos   = link.actual_pos;
                next_vel   = `SLSS_POS_ZERO;
                next_state = SLSS_CHECK;
            end
            SLSS_CHECK: begin
                next_pos = link.actual_pos;
                if (!limit_bit || user_mode == SLSS_MODE_PP || user_mode == SLSS_MODE_PV ||
                    user_mode == SLSS_MODE_PT || user_mode == SLSS_MODE_JOG) begin
                    next_state = SLSS_BACK;
                end
            end
            SLSS_BACK: begin
                // move away from the active limit
                next_pos   = at_upper ? link.actual_pos - back_step
                                      : link.actual_pos + back_step;
                next_vel   = at_upper ? -back_step : back_step;
                next_state = SLSS_RUN;
            end
            default: next_state = SLSS_RUN;
        endcase
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= SLSS_RUN;
            pos   <= `SLSS_POS_ZERO;
            vel   <= `SLSS_POS_ZERO;
        end else begin
            state <= next_state;
            pos   <= next_pos;
            vel   <= next_vel;
        end
    end

    always_comb begin
        link.mode                = user_mode;
        link.target_pos          = pos;
        link.target_vel          = vel;
        link.ctrl_upper_limit_in = user_upper_in;
        link.ctrl_lower_limit_in = user_lower_in;
        link.homing_done         = homing_finish;
        need_homing              = !link.home_valid;
        rec_state                = state;
    end
endmodule // slss_controller

// >>> verification/slss_limit_props.sv
`timescale 1ns/1ns
module slss_limit_props (
    input wire logic                 clk,
    input wire logic                 reset_n,
    input wire slss_pkg::slss_mode_t   mode,
    input wire slss_pkg::slss_pos_t    target_pos,
    input wire slss_pkg::slss_pos_t    target_vel,
    input wire logic                 ctrl_upper_limit_in,
    input wire logic                 ctrl_lower_limit_in,
    input wire slss_pkg::slss_status_t status_word,
    input wire slss_pkg::slss_pos_t    actual_pos,
    input wire logic                 homing_done,
    input wire logic                 home_valid
);
    import slss_pkg::*;
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_home_needs_run: assert property (!home_valid && !homing_done |=> !home_valid)
        else $error("home came back without a homing run");
    chk_home_from_run: assert property ($rose(home_valid) |-> $past(homing_done) || $past(homing_done, 2))
        else $error("home set with no homing pulse before it");
    chk_homing_pulse: assert property ($rose(homing_done) |=> !homing_done)
        else $error("homing done held longer than one cycle");
    chk_home_restore: assert property (homing_done && !status_word[12] |-> ##[1:2] home_valid)
        else $error("homing run did not restore home");
    chk_home_lost_cause: assert property ($fell(home_valid) |-> $past(status_word[12]) && $past(mode) == SLSS_MODE_CSP)
        else $error("home lost outside a csp overrun");
    chk_home_hold_run: assert property (home_valid && !status_word[12] |=> home_valid)
        else $error("home lost with no travel end latched");
    chk_csp_follow_only: assert property (mode == SLSS_MODE_CSP && status_word[12] && $past(status_word[12]) && $changed(target_pos) |-> target_pos == $past(actual_pos))
        else $error("csp target advanced at a travel end");
    chk_csp_check_bit: assert property (mode == SLSS_MODE_CSP && $changed(target_pos) && target_pos != $past(actual_pos) |-> !$past(status_word[12]))
        else $error("csp target reversed before limit bit cleared");
    chk_csv_vel_hold: assert property (mode == SLSS_MODE_CSV && $changed(target_vel) && target_vel != 32'sh0 |-> !$past(status_word[12]))
        else $error("csv velocity changed while limit bit set");
    // main scenarios: home lost, csv limit, homing
    cover property ($fell(home_valid));
    cover property (mode == SLSS_MODE_CSV && $rose(status_word[12]));
    cover property ($rose(homing_done));
endmodule // slss_limit_props

// >>> verification/stroke_limit_stop_supervisor_bench.sv
`timescale 1ns/1ns
module stroke_limit_stop_supervisor_bench;
    import slss_pkg::*;
    logic       clk;          // 25 MHz
    logic       reset_n;      // async, active low
    logic [2:0] pins;         // raw pins, high = on
    logic [7:0] map_a, map_b; // functions of pins 0 and 1
    logic [6:0] cfg;          // warn, auto, scope, src, erased, pole sel, pole act
    logic       dir;          // travel direction
    slss_mode_t umode;        // mode asked of the controller
    slss_pos_t  upos;         // wanted position
    logic [1:0] ulim;         // controller limits, upper then lower
    logic       hfin;         // homing finished
    logic [3:0] seen;         // stop, upper, lower, warning
    logic       alarm, erased, prox, need;
    int         error_cnt, checks, cyc;
    slss_if link();
    slss_device slss_device_inst (.clk(clk), .reset_n(reset_n), .link(link), .input_pin(pins),
        .input_map_a(map_a), .input_map_b(map_b), .input_map_c(8'h22),
        .limit_warning_select(cfg[6]), .travel_end_auto_on(cfg[5]), .limit_enable_scope(cfg[4]),
        .sensor_source_select(cfg[3]), .erased_output_select(cfg[2]),
        .pole_detect_limit_select(cfg[1]), .pole_detect_active(cfg[0]),
        .travel_direction_select(dir), .motor_pos(32'sh00000064), .motor_stop(seen[3]),
        .upper_travel_limit(seen[2]), .lower_travel_limit(seen[1]),
        .travel_limit_warning(seen[0]), .command_error_alarm(alarm),
        .position_erased_out(erased), .home_proximity(prox));
    slss_controller slss_controller_inst (.clk(clk), .reset_n(reset_n), .link(link),
        .user_mode(umode), .user_pos(upos), .user_vel(32'sh00000010),
        .back_step(32'sh00000005), .user_upper_in(ulim[1]), .user_lower_in(ulim[0]),
        .at_upper(1'b1), .homing_finish(hfin), .need_homing(need), .rec_state());
    slss_limit_props slss_limit_props_inst (.clk(clk), .reset_n(reset_n), .mode(link.mode),
        .target_pos(link.target_pos), .target_vel(link.target_vel),
        .ctrl_upper_limit_in(link.ctrl_upper_limit_in),
        .ctrl_lower_limit_in(link.ctrl_lower_limit_in), .status_word(link.status_word),
        .actual_pos(link.actual_pos), .homing_done(link.homing_done),
        .home_valid(link.home_valid));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // hang guard, about five times the four hundred cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic chk_vec(input string what, input logic [3:0] exp, input logic [3:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_pos(input string what, input slss_pos_t exp, input slss_pos_t got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_vec(what, {3'h0, exp}, {3'h0, got});
    endtask
    // drop pins, look once sync has passed, then release and let recovery finish
    task automatic limit_case(input logic [2:0] p, input logic [3:0] exp);
        @(negedge clk);
        pins = p;
        repeat (4) @(negedge clk);
        chk_vec("limit outputs", exp, seen);
        pins = 3'h7;
        ulim = 2'h3;
        repeat (8) @(negedge clk);
    endtask
    // upper end held: csp and csv freeze, then reverse once the bit clears;
    // profile, table and jog reverse at once while the end is still held
    task automatic recover_case(input logic quick);
        slss_pos_t hold_pos; // target expected while the end is held
        slss_pos_t hold_vel;
        hold_pos = quick ? 32'sh0000005F : 32'sh00000064;
        hold_vel = quick ? 32'shFFFFFFFB : 32'sh00000000;
        @(negedge clk);
        pins = 3'h6;
        repeat (4) @(negedge clk);
        upos = 32'sh000000C8;
        repeat (3) @(negedge clk);
        chk_pos("held target", hold_pos, link.target_pos);
        chk_pos("held velocity", hold_vel, link.target_vel);
        chk_bit("no overrun at end", 1'b0, alarm);
        pins = 3'h7;
        upos = 32'sh00000064;
        repeat (2) @(negedge clk);
        if (!quick) begin
            chk_pos("target before clear", 32'sh00000064, link.target_pos);
        end
        repeat (3) @(negedge clk);
        if (!quick) begin
            chk_pos("reversed target", 32'sh0000005F, link.target_pos);
            chk_pos("reversed velocity", 32'shFFFFFFFB, link.target_vel);
        end
        repeat (6) @(negedge clk);
    endtask
    task automatic home();
        @(negedge clk);
        hfin = 1'b1;
        @(negedge clk);
        hfin = 1'b0;
        repeat (4) @(negedge clk);
        chk_bit("home valid", 1'b1, link.home_valid);
        chk_bit("alarm after homing", 1'b0, alarm);
    endtask
    // command overruns the detection point at 100 by the given target
    task automatic overrun_case(input slss_pos_t p, input logic sel, input logic [1:0] exp);
        @(negedge clk);
        cfg[2] = sel;
        upos = p;
        pins = 3'h6;
        repeat (6) @(negedge clk);
        chk_vec("alarm erased", {2'h0, exp}, {2'h0, alarm, erased});
        chk_bit("need homing", exp[1], need);
        pins = 3'h7;
        upos = 32'sh00000064;
        repeat (8) @(negedge clk);
        home();
    endtask
    task automatic t_modes();
        for (int m = 0; m < 6; m++) begin
            umode = slss_mode_t'(m[2:0]);
            limit_case(3'h6, 4'hB);
            recover_case(m >= 2);
        end
        umode = SLSS_MODE_CSP;
        $display("modes test done");
    endtask
    task automatic t_mapping();
        dir = 1'b1;
        limit_case(3'h6, 4'hD);
        limit_case(3'h5, 4'hB);
        dir = 1'b0;
        map_a = 8'h0B;
        map_b = 8'h0A;
        limit_case(3'h6, 4'hD);
        map_a = 8'h0A;
        map_b = 8'h0B;
        chk_bit("proximity", 1'b1, prox);
        $display("mapping test done");
    endtask
    task automatic t_config();
        cfg = 7'h40;
        limit_case(3'h6, 4'hA);
        cfg = 7'h20;
        limit_case(3'h4, 4'h6);
        cfg = 7'h10;
        limit_case(3'h6, 4'h2);
        umode = SLSS_MODE_HM;
        limit_case(3'h6, 4'hB);
        umode = SLSS_MODE_CSP;
        cfg = 7'h48;
        ulim = 2'h1;
        limit_case(3'h4, 4'hA);
        cfg = 7'h03;
        limit_case(3'h6, 4'h2);
        cfg = 7'h01;
        limit_case(3'h6, 4'hB);
        cfg = 7'h00;
        $display("config test done");
    endtask
    task automatic t_overrun();
        overrun_case(32'sh00000082, 1'b1, 2'h0);
        overrun_case(32'sh00000083, 1'b0, 2'h2);
        overrun_case(32'sh00000045, 1'b1, 2'h3);
        $display("overrun test done");
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        {error_cnt, checks} = '0;
        {reset_n, hfin, dir, cfg} = '0;
        pins = 3'h7;
        ulim = 2'h3;
        map_a = 8'h0A;
        map_b = 8'h0B;
        umode = SLSS_MODE_CSP;
        upos = 32'sh00000064;
        repeat (5) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        home();
        t_modes();
        t_mapping();
        t_config();
        t_overrun();
        test_done();
    end
endmodule // stroke_limit_stop_supervisor_bench
